// ### hw/wdt_pkg.sv
// package for the wake-up down timer: register map, field layout,
// reset values, source codes and shared decode functions.
// assumes a 32-bit AHB-Lite register window decoded on haddr[7:0].
`default_nettype none

package wdt_pkg;

  // ********************************************************************
  // register byte offsets
  // ********************************************************************
  localparam logic [7:0] WDT_OFF_CTRL   = 8'h00;
  localparam logic [7:0] WDT_OFF_RELOAD = 8'h04;
  localparam logic [7:0] WDT_OFF_COUNT  = 8'h08;
  localparam logic [7:0] WDT_OFF_IEN    = 8'h10;
  localparam logic [7:0] WDT_OFF_STAT   = 8'h14;
  localparam logic [7:0] WDT_OFF_CLR    = 8'h1C;
  localparam logic [7:0] WDT_OFF_DBG    = 8'h20;

  // ********************************************************************
  // field positions in the control word
  // ********************************************************************
  localparam int WDT_POS_EN  = 0;
  localparam int WDT_POS_SRC = 4;
  localparam int WDT_POS_PRS = 8;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [15:0] WDT_RST_RELOAD = 16'hFFFF;
  localparam logic [15:0] WDT_RST_COUNT  = 16'h0000;
  localparam logic [31:0] WDT_CLR_READ   = 32'h0000_0001;

  // ********************************************************************
  // clock source select codes
  // ********************************************************************
  localparam logic [2:0] WDT_SRC_HS_INT = 3'h0;
  localparam logic [2:0] WDT_SRC_HS_XTL = 3'h1;
  localparam logic [2:0] WDT_SRC_LS_INT = 3'h2;
  localparam logic [2:0] WDT_SRC_LS_XTL = 3'h3;
  localparam logic [2:0] WDT_SRC_EXT    = 3'h4;
  localparam int         WDT_NUM_SRC    = 5;

  // control word carried as one bundle
  typedef struct packed {
    logic       dbg_stop;
    logic [3:0] prescale_select;
    logic [2:0] src;
    logic       en;
  } wdt_cfg_t;

  localparam wdt_cfg_t WDT_RST_CFG = '{dbg_stop: 1'b0, prescale_select: 4'h1,
                                       src: 3'h0, en: 1'b0};

  // low-speed sources keep running in deep sleep
  function automatic logic wdt_low_speed(input logic [2:0] s);
    return (s == WDT_SRC_LS_INT) || (s == WDT_SRC_LS_XTL);
  endfunction

  // terminal value of the prescaler: 2**n - 1; reserved 0 acts as 1
  function automatic logic [14:0] wdt_prs_last(input logic [3:0] p);
    logic [15:0] m;
    m = 16'h0001 << ((p == 4'h0) ? 4'h1 : p);
    return m[14:0] - 15'h0001;
  endfunction

endpackage

`default_nettype wire

// ### hw/wdt_tick.sv
// prescaler of the wake-up timer: picks one source level, counts its
// rising edges and emits a one-cycle counter_tick every 2**n edges, or every 2 edges for the reserved n of 0.
// assumes source levels are synchronous to the system clock and slower
// than half of it.
`timescale 1ns/1ns
`default_nettype none

module wdt_tick (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // sources and settings
  input  wire logic [4:0] i_src,
  input  wire logic [2:0] i_sel,
  input  wire logic [3:0] i_prs,
  input  wire logic       i_run,
  input  wire logic       i_clr,
  // tick out
  output logic            o_tick
);

  logic        sel_lvl;
  logic        prev;
  logic        next_prev;
  logic [14:0] div;
  logic [14:0] next_div;
  logic        next_tick;
  logic        edge_seen;

  // source mux; codes 5..7 select nothing
  always_comb begin
    sel_lvl = 1'b0;
    if (i_sel < 3'(wdt_pkg::WDT_NUM_SRC)) begin
      sel_lvl = i_src[i_sel];
    end
  end

  // edge detect and divider
  always_comb begin
    next_prev = sel_lvl;
    edge_seen = sel_lvl & ~prev;
    next_div  = div;
    next_tick = 1'b0;
    if (i_clr) begin
      next_div = 15'h0000;
    end else if (edge_seen && i_run) begin
      if (div >= wdt_pkg::wdt_prs_last(i_prs)) begin
        next_div  = 15'h0000;
        next_tick = 1'b1;
      end else begin
        next_div = div + 15'h0001;
      end
    end
  end

  // state registers, frozen while clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev   <= 1'b0;
      div    <= 15'h0000;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      prev   <= next_prev;
      div    <= next_div;
      o_tick <= next_tick;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  a_tick_needs_run: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && !i_run) |=> !o_tick)
    else $error("tick issued while halted");
  a_clr_resets_div: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_clr) |=> (div == 15'h0000 && !o_tick))
    else $error("prescaler not cleared on disable");

endmodule // wdt_tick

`default_nettype wire

// ### hw/wdt_top.sv
// wake-up down timer: AHB-Lite register slave, 16-bit down counter,
// underflow flag with interrupt and deep-sleep wake request.
// assumes a single AHB-Lite master and oscillator levels synchronous
// to I_SYS_CLK; zero-wait-state slave, always OKAY.
//
// Notes on behaviour
// - one 16-bit down counter driven by the prescaler tick.
// - source picked from five: four oscillators or the external pin.
// - a 4-bit prescale field divides the source into counter ticks.
// - prescale n divides by 2**n; zero is reserved, not to be used.
// - 16-bit reload value; each period is reload plus one ticks.
// - enabling loads reload into counter; each tick decrements by one.
// - counting past zero sets underflow flag and reloads the counter.
// - reload writes never disturb the count; used at next reload.
// - timing and event counting differ only in chosen source.
// - low-speed sources keep counting in deep sleep and can wake.
// - interrupt raised only when the underflow enable is set.
// - writing 0 to the clear register bit clears the underflow flag.
// - source code 4 selects the external count pin.
// - debug halt with the stop bit set suspends counting.
`timescale 1ns/1ns
`default_nettype none

module wdt_top (
  // clock, reset, enable
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CLK_EN,
  // ahb-lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic [31:0]      O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // clock sources and external count pin
  input  wire logic        I_HIGH_SPEED_INTERNAL_OSC,
  input  wire logic        I_HIGH_SPEED_CRYSTAL_OSC,
  input  wire logic        I_LOW_SPEED_INTERNAL_OSC,
  input  wire logic        I_LOW_SPEED_CRYSTAL_OSC,
  input  wire logic        I_EXTERNAL_COUNT_PIN,
  // system state
  input  wire logic        I_DEEP_SLEEP,
  input  wire logic        I_DEBUG_HALTED,
  // requests
  output logic             O_UNDERFLOW_IRQ,
  output logic             O_WAKE_REQ
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  wdt_pkg::wdt_cfg_t cfg;
  wdt_pkg::wdt_cfg_t next_cfg;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [7:0]  wr_addr;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_rdata;
  logic [15:0] reload_value;
  logic [15:0] next_reload_value;
  logic [15:0] down_counter;
  logic [15:0] next_down_counter;
  logic        irq_enable;
  logic        next_irq_enable;
  logic        underflow_flag;
  logic        next_underflow_flag;
  logic        next_irq;
  logic        next_wake;
  logic        take;
  logic        clr_req;
  logic        underflow;
  logic        run;
  logic        counter_tick;
  logic [4:0]  src_bus;

  // ********************************************************************
  // bus front end
  // ********************************************************************

  // address phase is taken when a selected NONSEQ or SEQ transfer (htrans[1] set) sees hready
  assign take = I_HSEL & I_HTRANS[1] & I_HREADY;

  // read data is latched at the address phase so hrdata is a flop
  always_comb begin
    next_wr_pend = take & I_HWRITE;
    next_wr_addr = take ? I_HADDR[7:0] : wr_addr;
    next_rdata   = 32'h0000_0000;
    if (take && !I_HWRITE) begin
      unique case (I_HADDR[7:0])
        wdt_pkg::WDT_OFF_CTRL: begin
          next_rdata[wdt_pkg::WDT_POS_EN]        = cfg.en;
          next_rdata[wdt_pkg::WDT_POS_SRC +: 3]  = cfg.src;
          next_rdata[wdt_pkg::WDT_POS_PRS +: 4]  = cfg.prescale_select;
        end
        wdt_pkg::WDT_OFF_RELOAD: next_rdata[15:0] = reload_value;
        wdt_pkg::WDT_OFF_COUNT:  next_rdata[15:0] = down_counter;
        wdt_pkg::WDT_OFF_IEN:    next_rdata[0]    = irq_enable;
        wdt_pkg::WDT_OFF_STAT:   next_rdata[0]    = underflow_flag;
        wdt_pkg::WDT_OFF_CLR:    next_rdata       = wdt_pkg::WDT_CLR_READ;
        wdt_pkg::WDT_OFF_DBG:    next_rdata[0]    = cfg.dbg_stop;
        default:                 next_rdata       = 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************************
  // register writes (data phase)
  // ********************************************************************

  // writes land one cycle after the address phase, with hwdata
  always_comb begin
    next_cfg          = cfg;
    next_reload_value = reload_value;
    next_irq_enable   = irq_enable;
    clr_req           = 1'b0;
    if (wr_pend) begin
      unique case (wr_addr)
        wdt_pkg::WDT_OFF_CTRL: begin
          next_cfg.en  = I_HWDATA[wdt_pkg::WDT_POS_EN];
          next_cfg.src = I_HWDATA[wdt_pkg::WDT_POS_SRC +: 3];
          next_cfg.prescale_select = I_HWDATA[wdt_pkg::WDT_POS_PRS +: 4];
        end
        wdt_pkg::WDT_OFF_RELOAD: next_reload_value = I_HWDATA[15:0];
        wdt_pkg::WDT_OFF_IEN:    next_irq_enable   = I_HWDATA[0];
        wdt_pkg::WDT_OFF_CLR:    clr_req           = ~I_HWDATA[0];
        wdt_pkg::WDT_OFF_DBG:    next_cfg.dbg_stop = I_HWDATA[0];
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // prescaler
  // ********************************************************************

  // high-speed sources are dead in deep sleep, so only low-speed run
  assign run = cfg.en & next_cfg.en
             & ~(I_DEBUG_HALTED & cfg.dbg_stop)
             & ~(I_DEEP_SLEEP & ~wdt_pkg::wdt_low_speed(cfg.src));

  assign src_bus = {I_EXTERNAL_COUNT_PIN, I_LOW_SPEED_CRYSTAL_OSC,
                    I_LOW_SPEED_INTERNAL_OSC, I_HIGH_SPEED_CRYSTAL_OSC,
                    I_HIGH_SPEED_INTERNAL_OSC};

  wdt_tick u_tick (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CLK_EN),
    .i_src   (src_bus),
    .i_sel   (cfg.src),
    .i_prs   (cfg.prescale_select),
    .i_run   (run),
    .i_clr   (~cfg.en),
    .o_tick  (counter_tick)
  );

  // ********************************************************************
  // down counter and underflow flag
  // ********************************************************************

  // a tick landing while disabling is dropped: stop is immediate
  always_comb begin
    next_down_counter = down_counter;
    underflow         = 1'b0;
    if (next_cfg.en && !cfg.en) begin
      next_down_counter = reload_value;
    end else if (cfg.en && next_cfg.en && counter_tick) begin
      if (down_counter == 16'h0000) begin
        underflow         = 1'b1;
        next_down_counter = reload_value;
      end else begin
        next_down_counter = down_counter - 16'h0001;
      end
    end
  end

  // set wins over a clear in the same cycle
  always_comb begin
    next_underflow_flag = underflow | (underflow_flag & ~clr_req);
    next_irq  = next_underflow_flag & next_irq_enable;
    next_wake = next_irq & I_DEEP_SLEEP
              & wdt_pkg::wdt_low_speed(next_cfg.src);
  end

  // ********************************************************************
  // state registers
  // ********************************************************************

  // all state freezes while I_CLK_EN is low
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      cfg             <= wdt_pkg::WDT_RST_CFG;
      wr_pend         <= 1'b0;
      wr_addr         <= 8'h00;
      O_HRDATA        <= 32'h0000_0000;
      O_HREADYOUT     <= 1'b1;
      O_HRESP         <= 1'b0;
      reload_value    <= wdt_pkg::WDT_RST_RELOAD;
      down_counter    <= wdt_pkg::WDT_RST_COUNT;
      irq_enable      <= 1'b0;
      underflow_flag  <= 1'b0;
      O_UNDERFLOW_IRQ <= 1'b0;
      O_WAKE_REQ      <= 1'b0;
    end else if (I_CLK_EN) begin
      cfg             <= next_cfg;
      wr_pend         <= next_wr_pend;
      wr_addr         <= next_wr_addr;
      O_HRDATA        <= next_rdata;
      O_HREADYOUT     <= 1'b1;
      O_HRESP         <= 1'b0;
      reload_value    <= next_reload_value;
      down_counter    <= next_down_counter;
      irq_enable      <= next_irq_enable;
      underflow_flag  <= next_underflow_flag;
      O_UNDERFLOW_IRQ <= next_irq;
      O_WAKE_REQ      <= next_wake;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  a_enable_loads: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (I_CLK_EN && next_cfg.en && !cfg.en)
      |=> (down_counter == $past(reload_value)))
    else $error("enable did not load reload value");

  a_tick_decrements: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (I_CLK_EN && cfg.en && !wr_pend && counter_tick && down_counter != 0)
      |=> (down_counter == $past(down_counter) - 16'h0001))
    else $error("tick did not decrement counter");

  a_underflow_reload: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (I_CLK_EN && cfg.en && !wr_pend && counter_tick && down_counter == 0)
      |=> (down_counter == $past(reload_value) && underflow_flag))
    else $error("underflow did not reload and flag");

  a_count_holds: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (cfg.en && !counter_tick) |=> $stable(down_counter))
    else $error("counter moved without a tick");

  a_irq_gated: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (I_CLK_EN && !next_irq_enable) |=> !O_UNDERFLOW_IRQ)
    else $error("interrupt raised while masked");

  a_irq_follows: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    O_UNDERFLOW_IRQ |-> (underflow_flag && irq_enable))
    else $error("interrupt without flag and enable");

  a_set_beats_clear: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (I_CLK_EN && underflow && clr_req) |=> underflow_flag)
    else $error("underflow lost to a clear");

  a_clear_works: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (I_CLK_EN && clr_req && !underflow) |=> !underflow_flag)
    else $error("flag not cleared");

  // enabling while halted is legal and loads, so only running counts
  a_debug_stops: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    (I_DEBUG_HALTED && cfg.dbg_stop && cfg.en && !counter_tick)[*2]
      |-> $stable(down_counter))
    else $error("counter ran in debug halt");

  a_wake_low_speed: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_RST_N)
    O_WAKE_REQ |-> (wdt_pkg::wdt_low_speed(cfg.src) && O_UNDERFLOW_IRQ))
    else $error("wake request from high-speed source");

  c_underflow: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    underflow);
  c_irq: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    $rose(O_UNDERFLOW_IRQ));
  c_set_clear: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    underflow && clr_req);
  c_wake: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_WAKE_REQ);

endmodule // wdt_top

`default_nettype wire

// ### test/wdt_src_model.sv
// source model for the wake-up timer: four free-running oscillators
// and an external count pin that sends bursts of pulses on request.
// assumes the testbench asks for a burst only while o_busy is low.
`timescale 1ns/1ns
`default_nettype none

module wdt_src_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // burst request
  input  wire logic       i_go,
  input  wire logic [7:0] i_num,
  // source levels
  output logic [3:0]      o_osc,
  output logic            o_ext,
  output logic            o_busy
);
  logic [2:0] cnt [4];
  logic [9:0] ph;

  // oscillator k toggles every k+1 cycles, so each rate differs
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (!i_rst_n) begin
        cnt[k]   <= 3'h0;
        o_osc[k] <= 1'b0;
      end else if (cnt[k] == 3'(k)) begin
        cnt[k]   <= 3'h0;
        o_osc[k] <= ~o_osc[k];
      end else begin
        cnt[k] <= cnt[k] + 3'h1;
      end
    end
  end

  // four cycles a pulse: one fixed period per burst
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      ph <= 10'h000;
    else if (i_go && ph == 10'h000)
      ph <= {i_num, 2'b00};
    else if (ph != 10'h000)
      ph <= ph - 10'h001;
  end

  // idle pin rests low, so no stray edge reaches the counter
  assign o_ext  = ph[1];
  assign o_busy = (ph != 10'h000);
endmodule // wdt_src_model

`default_nettype wire

// ### test/tb_wakeup_down_timer.sv
// testbench of the wake-up timer: ahb-lite tasks, one task a scenario.
// assumes wdt_src_model feeds all five sources.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH %0t got %h exp %h", $time, g, e); \
  end end

module tb_wakeup_down_timer;
  logic        clk, rst_n, hsel, hwrite, sleep, halted, go, busy;
  logic        hready, hresp, irq, wake, ext;
  logic        ce;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0]  osc;
  logic [7:0]  num;
  int          miscompares, n_compared;
  localparam logic [2:0] EXT = wdt_pkg::WDT_SRC_EXT;

  always #10 clk = ~clk;

  wdt_top dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(ce),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .I_HIGH_SPEED_INTERNAL_OSC(osc[0]),
    .I_HIGH_SPEED_CRYSTAL_OSC(osc[1]), .I_LOW_SPEED_INTERNAL_OSC(osc[2]),
    .I_LOW_SPEED_CRYSTAL_OSC(osc[3]), .I_EXTERNAL_COUNT_PIN(ext),
    .I_DEEP_SLEEP(sleep), .I_DEBUG_HALTED(halted),
    .O_UNDERFLOW_IRQ(irq), .O_WAKE_REQ(wake));

  wdt_src_model src (.i_clk(clk), .i_rst_n(rst_n), .i_go(go),
    .i_num(num), .o_osc(osc), .o_ext(ext), .o_busy(busy));

  // ******************************************************************
  // bus and helper tasks
  // ******************************************************************
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b1; haddr <= 32'(a);
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
  endtask

  // read data taken at the edge that ends the data phase
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b0; haddr <= 32'(a);
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0;
    wait_rdy();
    `CHK(hrdata, e)
    `CHK(hresp, 1'b0)
    `CHK(hready, 1'b1)
  endtask

  function automatic logic [31:0] ctl(logic [2:0] s, logic [3:0] p,
                                      logic en);
    return {20'h0_0000, p, 1'b0, s, 3'h0, en};
  endfunction

  // source and prescaler set before enable, never while running
  task automatic setup(logic [2:0] s, logic [3:0] p, logic [15:0] rl,
                       logic ien);
    wr(wdt_pkg::WDT_OFF_CTRL, ctl(s, p, 1'b0));
    wr(wdt_pkg::WDT_OFF_CLR, 32'h0000_0000);
    wr(wdt_pkg::WDT_OFF_RELOAD, {16'h0000, rl});
    wr(wdt_pkg::WDT_OFF_IEN, {31'h0, ien});
    wr(wdt_pkg::WDT_OFF_CTRL, ctl(s, p, 1'b1));
  endtask

  // burst of n pin pulses, then room for tick and count update
  task automatic pulses(input logic [7:0] n);
    int k;
    go <= 1'b1; num <= n;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy !== 1'b0 && k < 2000);
    if (busy !== 1'b0) begin
      miscompares++;
      report_and_stop();
    end
    repeat (3) @(posedge clk);
  endtask

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_regs();
    chk_rd(wdt_pkg::WDT_OFF_CTRL, 32'h0000_0100);
    chk_rd(wdt_pkg::WDT_OFF_RELOAD, 32'h0000_FFFF);
    chk_rd(wdt_pkg::WDT_OFF_IEN, 32'h0000_0000);
    chk_rd(wdt_pkg::WDT_OFF_STAT, 32'h0000_0000);
    chk_rd(wdt_pkg::WDT_OFF_CLR, 32'h0000_0001);
    chk_rd(wdt_pkg::WDT_OFF_DBG, 32'h0000_0000);
    wr(wdt_pkg::WDT_OFF_COUNT, 32'h0000_FFFF);
    wr(8'h0C, 32'h0000_FFFF);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0000);
    chk_rd(8'h0C, 32'h0000_0000);
  endtask

  // event counting on the pin, reload swapped in mid-period
  task automatic t_event();
    setup(EXT, 4'h1, 16'h0002, 1'b1);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0002);
    wr(wdt_pkg::WDT_OFF_RELOAD, 32'h0000_0005);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0002);
    pulses(8'd2);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0001);
    pulses(8'd2);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0000);
    chk_rd(wdt_pkg::WDT_OFF_STAT, 32'h0000_0000);
    pulses(8'd2);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0005);
    chk_rd(wdt_pkg::WDT_OFF_STAT, 32'h0000_0001);
    `CHK(irq, 1'b1)
    wr(wdt_pkg::WDT_OFF_CLR, 32'h0000_0001);
    chk_rd(wdt_pkg::WDT_OFF_STAT, 32'h0000_0001);
    wr(wdt_pkg::WDT_OFF_CLR, 32'h0000_0000);
    chk_rd(wdt_pkg::WDT_OFF_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
  endtask

  // divide by four; underflow with the interrupt masked
  task automatic t_prescale();
    setup(EXT, 4'h2, 16'h0001, 1'b0);
    pulses(8'd3);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0001);
    pulses(8'd1);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0000);
    pulses(8'd4);
    chk_rd(wdt_pkg::WDT_OFF_STAT, 32'h0000_0001);
    `CHK(irq, 1'b0)
  endtask

  // a half-filled prescaler must not survive a disable
  task automatic t_disable();
    setup(EXT, 4'h1, 16'h0003, 1'b0);
    pulses(8'd1);
    wr(wdt_pkg::WDT_OFF_CTRL, ctl(EXT, 4'h1, 1'b0));
    pulses(8'd2);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0003);
    wr(wdt_pkg::WDT_OFF_CTRL, ctl(EXT, 4'h1, 1'b1));
    pulses(8'd1);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0003);
    pulses(8'd1);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0002);
  endtask

  task automatic t_debug();
    wr(wdt_pkg::WDT_OFF_DBG, 32'h0000_0001);
    setup(EXT, 4'h1, 16'h0003, 1'b0);
    halted <= 1'b1;
    pulses(8'd2);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0003);
    wr(wdt_pkg::WDT_OFF_DBG, 32'h0000_0000);
    pulses(8'd2);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0002);
    halted <= 1'b0;
  endtask

  // clock enable low freezes prescaler and counter alike
  task automatic t_freeze();
    setup(EXT, 4'h1, 16'h0001, 1'b0);
    ce <= 1'b0;
    pulses(8'h02);
    ce <= 1'b1;
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0001);
    pulses(8'h02);
    chk_rd(wdt_pkg::WDT_OFF_COUNT, 32'h0000_0000);
  endtask

  // every oscillator, awake and in deep sleep
  task automatic t_sources();
    logic ls, w;
    for (int s = 0; s < 4; s++) begin
      for (int sl = 0; sl < 2; sl++) begin
        sleep <= 1'(sl);
        setup(3'(s), 4'h1, 16'h0000, 1'b1);
        repeat (40) @(posedge clk);
        ls = (s >= 2);
        w = ls && (sl == 1);
        chk_rd(wdt_pkg::WDT_OFF_STAT, {31'h0, ls || sl == 0});
        `CHK(wake, w)
        wr(wdt_pkg::WDT_OFF_CTRL, ctl(3'(s), 4'h1, 1'b0));
      end
    end
    sleep <= 1'b0;
  endtask

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    clk = 1'b0; rst_n = 1'b0; hsel = 1'b0; htrans = 2'h0;
    hwrite = 1'b0; haddr = 32'h0000_0000; hwdata = 32'h0000_0000;
    sleep = 1'b0; halted = 1'b0; go = 1'b0; num = 8'h00;
    ce = 1'b1;
    miscompares = 0; n_compared = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_event();
    t_prescale();
    t_disable();
    t_debug();
    t_freeze();
    t_sources();
    report_and_stop();
  end
endmodule // tb_wakeup_down_timer

`default_nettype wire
